//--- verilog/agv_regs.sv
// agv_regs: gain and volume register bank of the audio amplifier.
// assumes a register write/read port decoded by the serial interface logic,
// same clock, and a temperature word from the on-die sensor.
`timescale 1ns/10ps
module agv_regs
   import agv_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst_b,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [ADDR_W-1:0]       reg_addr,
   input  wire logic [DATA_W-1:0]       reg_wdata,
   input  wire logic [HPG_W-1:0]        headphone_gain_select_wr,
   input  wire logic                    headphone_gain_select_we,
   input  wire logic [MODE_W-1:0]       mux_mode,
   input  wire logic [TEMP_W-1:0]       die_temp_c,
   output logic      [DATA_W-1:0]       reg_rdata,
   output logic                         reg_ack,
   output logic      [HPG_W-1:0]        headphone_gain_select,
   output logic signed [DB_W-1:0]       hp_left_total_db,
   output logic signed [DB_W-1:0]       hp_right_total_db,
   output logic signed [DB_W-1:0]       spk_left_total_db,
   output logic signed [DB_W-1:0]       spk_right_total_db,
   output logic                         amp_shutdown
);

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [CODE_W-1:0]      mono_vol;
      logic [CODE_W-1:0]      pair1_vol;
      logic [CODE_W-1:0]      pair2_vol;
      logic [HPG_W-1:0]       hp_sel;
      logic [MODE_W-1:0]      mode_s1;
      logic [MODE_W-1:0]      mode;
      logic [TEMP_W-1:0]      temp_s1;
      logic [TEMP_W-1:0]      temp;
      logic                   hot;
      logic [DATA_W-1:0]      rdata;
      logic                   ack;
      logic signed [DB_W-1:0] hp_l;
      logic signed [DB_W-1:0] hp_r;
      logic signed [DB_W-1:0] spk_l;
      logic signed [DB_W-1:0] spk_r;
   } agv_state_t;

   agv_state_t state_q;
   agv_state_t state_d;

   agv_gain_if gi ();

   agv_gain_map u_map (
      .g (gi.mapper)
   );

   // pad a 5-bit code into a byte, upper bits zero
   // bits 7..5 of every volume register are unused and never stored
   function automatic logic [DATA_W-1:0] agv_pad(input logic [CODE_W-1:0] c);
      agv_pad = {{(DATA_W-CODE_W){1'b0}}, c};
   endfunction : agv_pad

   ////////////////////////////////////////////////////////////////////////
   // register index decode, one-hot so each target is a single bit; the
   // write and the read path share it, so a register can never answer at
   // an index other than the one it is written at
   typedef enum logic [3:0] {
      AGV_SEL_NONE  = 4'h1,
      AGV_SEL_MONO  = 4'h2,
      AGV_SEL_PAIR1 = 4'h4,
      AGV_SEL_PAIR2 = 4'h8
   } agv_sel_t;

   function automatic agv_sel_t agv_decode(input logic [ADDR_W-1:0] a);
      case (a)
         MONO_INPUT_VOLUME_IDX:      agv_decode = AGV_SEL_MONO;
         STEREO_PAIR_ONE_VOLUME_IDX: agv_decode = AGV_SEL_PAIR1;
         STEREO_PAIR_TWO_VOLUME_IDX: agv_decode = AGV_SEL_PAIR2;
         // any other index is not part of this bank
         default:                    agv_decode = AGV_SEL_NONE;
      endcase
   endfunction : agv_decode

   agv_sel_t reg_sel;

   // one decode per cycle, used by both strobes
   assign reg_sel = agv_decode(reg_addr);

   ////////////////////////////////////////////////////////////////////////
   // channel code selection from the mux mode:
   //   mono and mute modes take the mono code
   //   single-ended and summed modes take the code of the pair in use
   //   both differential modes take pair one, for left and right alike
   // left and right always share one code; the pair two field only matters
   // in the single-ended and summed pair two modes
   always_comb begin
      gi.hp_sel = state_q.hp_sel;
      case (state_q.mode)
         3'h0: begin
            gi.left_code  = state_q.mono_vol;
            gi.right_code = state_q.mono_vol;
         end
         3'h1, 3'h5: begin
            gi.left_code  = state_q.pair1_vol;
            gi.right_code = state_q.pair1_vol;
         end
         3'h2, 3'h6: begin
            gi.left_code  = state_q.pair2_vol;
            gi.right_code = state_q.pair2_vol;
         end
         // pair one code steers both channels in differential mode
         MODE_STEREO_DIFF, 3'h4: begin
            gi.left_code  = state_q.pair1_vol;
            gi.right_code = state_q.pair1_vol;
         end
         default: begin
            gi.left_code  = state_q.mono_vol;
            gi.right_code = state_q.mono_vol;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state; latency in sys_clk edges from the input change:
   //   register write  -> stored code on the next edge
   //   stored code     -> totals one edge later, through the gain map
   //   mux_mode        -> two sync stages, then one edge for the totals
   //   die_temp_c      -> two sync stages, then one edge for amp_shutdown
   // a read answers with reg_ack and reg_rdata one edge after its strobe;
   // the data then holds until the next read, so a slow host can fetch it late
   always_comb begin
      state_d       = state_q;
      state_d.ack   = reg_wr | reg_rd;
      // mode and temperature come from other logic; synchronise anyway.
      // both are slow levels: a torn multi-bit sample shows for one cycle at
      // most, accepted here rather than paying for a handshake
      state_d.mode_s1 = mux_mode;
      state_d.mode    = state_q.mode_s1;
      state_d.temp_s1 = die_temp_c;
      state_d.temp    = state_q.temp_s1;
      // strictly above the trip point; at the trip temperature itself the
      // amplifiers keep running, and they restart once it is reached again
      state_d.hot     = (state_q.temp > TEMP_TRIP_C);

      // only bits 4..0 are stored; 7..5 dropped on write
      // a write to an unmapped index is dropped without trace
      if (reg_wr) begin
         case (reg_sel)
            AGV_SEL_MONO:
               state_d.mono_vol  = reg_wdata[VOL_MSB:VOL_LSB];
            AGV_SEL_PAIR1:
               state_d.pair1_vol = reg_wdata[VOL_MSB:VOL_LSB];
            AGV_SEL_PAIR2:
               state_d.pair2_vol = reg_wdata[VOL_MSB:VOL_LSB];
            default: ;
         endcase
      end
      // headphone select only changes through a register write
      // it has a load port of its own, its index lies outside this bank
      if (headphone_gain_select_we) begin
         state_d.hp_sel = headphone_gain_select_wr;
      end

      // read data, unmapped index reads zero
      if (reg_rd) begin
         case (reg_sel)
            AGV_SEL_MONO:  state_d.rdata = agv_pad(state_q.mono_vol);
            AGV_SEL_PAIR1: state_d.rdata = agv_pad(state_q.pair1_vol);
            AGV_SEL_PAIR2: state_d.rdata = agv_pad(state_q.pair2_vol);
            default:       state_d.rdata = '0;
         endcase
      end

      // total gains: input taper plus output stage
      // signed sums cannot wrap: the extremes are -80 and +30 dB
      state_d.hp_l  = DB_W'(gi.left_in_db + gi.hp_db);
      state_d.hp_r  = DB_W'(gi.right_in_db + gi.hp_db);
      state_d.spk_l = DB_W'(gi.left_in_db + SPK_GAIN_DB);
      state_d.spk_r = DB_W'(gi.right_in_db + SPK_GAIN_DB);
   end

   ////////////////////////////////////////////////////////////////////////
   // registers, synchronous active-low reset; sync stages live in the
   // struct too, so reset clears them with the rest. totals clear to zero
   // and only carry a real gain from the first edge after release
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_q           <= '0;
         state_q.mono_vol  <= VOL_RESET;
         state_q.pair1_vol <= VOL_RESET;
         state_q.pair2_vol <= VOL_RESET;
         state_q.hp_sel    <= HPG_RESET;
         state_q.mode_s1   <= MODE_RESET;
         state_q.mode      <= MODE_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // every output straight from the state register, no logic after the flops
   assign reg_rdata             = state_q.rdata;
   assign reg_ack               = state_q.ack;
   assign headphone_gain_select = state_q.hp_sel;
   assign hp_left_total_db      = state_q.hp_l;
   assign hp_right_total_db     = state_q.hp_r;
   assign spk_left_total_db     = state_q.spk_l;
   assign spk_right_total_db    = state_q.spk_r;
   assign amp_shutdown          = state_q.hot;

endmodule : agv_regs

//--- verilog/agv_pkg.sv
// agv_pkg: register map, field layouts, reset values and gain tables for the
// audio gain and volume register bank. assumes nothing beyond a sv compiler.
package agv_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int CODE_W = 5;
   localparam int HPG_W  = 2;
   localparam int MODE_W = 3;
   localparam int DB_W   = 8;

   // register indices, byte wide registers on the serial register port
   localparam logic [ADDR_W-1:0] MONO_INPUT_VOLUME_IDX      = 3'h4;
   localparam logic [ADDR_W-1:0] STEREO_PAIR_ONE_VOLUME_IDX = 3'h5;
   localparam logic [ADDR_W-1:0] STEREO_PAIR_TWO_VOLUME_IDX = 3'h6;

   // volume field sits in bits 4..0
   localparam int VOL_LSB = 0;
   localparam int VOL_MSB = 4;

   // reset values: volume reset not given, 0 dB code chosen
   localparam logic [CODE_W-1:0] VOL_RESET  = 5'h10;
   localparam logic [HPG_W-1:0]  HPG_RESET  = 2'h0;
   localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

   // headphone gain select codes
   localparam logic [HPG_W-1:0] HPG_PLUS6  = 2'h0;
   localparam logic [HPG_W-1:0] HPG_ZERO   = 2'h1;
   localparam logic [HPG_W-1:0] HPG_MINUS6 = 2'h2;
   localparam logic [HPG_W-1:0] HPG_MIN14  = 2'h3;

   // multiplexer mode that drives both channels from pair one volume
   localparam logic [MODE_W-1:0] MODE_STEREO_DIFF = 3'h3;

   // fixed loudspeaker stage gain, signed dB
   localparam logic signed [DB_W-1:0] SPK_GAIN_DB = 8'sh06;

   // thermal trip threshold in degrees celsius
   localparam int TEMP_W        = 9;
   localparam logic [TEMP_W-1:0] TEMP_TRIP_C = 9'h096;

   // audio taper, signed dB per code, index 0 .. 31
   localparam logic signed [DB_W-1:0] TAPER_DB [0:31] = '{
      -8'sd66, -8'sd56, -8'sd48, -8'sd44, -8'sd40, -8'sd36, -8'sd32, -8'sd28,
      -8'sd24, -8'sd21, -8'sd18, -8'sd15, -8'sd12, -8'sd9,  -8'sd6,  -8'sd3,
       8'sd0,   8'sd3,   8'sd5,   8'sd7,   8'sd9,   8'sd11,  8'sd13,  8'sd15,
       8'sd17,  8'sd18,  8'sd19,  8'sd20,  8'sd21,  8'sd22,  8'sd23,  8'sd24
   };

endpackage : agv_pkg

//--- verilog/agv_gain_if.sv
// agv_gain_if: carries the selected volume codes from the register bank
// to the gain mapper. assumes both ends on the same clock.
`timescale 1ns/10ps
interface agv_gain_if;
   import agv_pkg::*;
   logic [CODE_W-1:0] left_code;
   logic [CODE_W-1:0] right_code;
   logic [HPG_W-1:0]  hp_sel;
   logic signed [DB_W-1:0] left_in_db;
   logic signed [DB_W-1:0] right_in_db;
   logic signed [DB_W-1:0] hp_db;

   modport bank (output left_code, right_code, hp_sel,
                 input left_in_db, right_in_db, hp_db);
   modport mapper (input left_code, right_code, hp_sel,
                   output left_in_db, right_in_db, hp_db);
endinterface : agv_gain_if

//--- verilog/agv_gain_map.sv
// agv_gain_map: pure decode of volume codes and headphone select to dB.
// assumes codes come from registers in the bank.
`timescale 1ns/10ps
module agv_gain_map
   import agv_pkg::*;
(
   agv_gain_if.mapper g
);

   // headphone select decode
   function automatic logic signed [DB_W-1:0] agv_hp_db(input logic [HPG_W-1:0] s);
      case (s)
         HPG_PLUS6:  agv_hp_db = 8'sh06;
         HPG_ZERO:   agv_hp_db = 8'sh00;
         HPG_MINUS6: agv_hp_db = -8'sh06;
         HPG_MIN14:  agv_hp_db = -8'sh0E;
         default:    agv_hp_db = 8'sh00;
      endcase
   endfunction : agv_hp_db

   // audio taper lookup and headphone gain
   assign g.left_in_db  = TAPER_DB[g.left_code];
   assign g.right_in_db = TAPER_DB[g.right_code];
   assign g.hp_db       = agv_hp_db(g.hp_sel);

endmodule : agv_gain_map

//--- tb/agv_host_model.sv
// agv_host_model: register host for the bank's access port.
// assumes sys_clk is shared with the bank.
`timescale 1ns/10ps
module agv_host_model
   import agv_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              reg_ack,
   input  wire logic [DATA_W-1:0] reg_rdata,
   output logic                   reg_wr,
   output logic                   reg_rd,
   output logic [ADDR_W-1:0]      reg_addr,
   output logic [DATA_W-1:0]      reg_wdata,
   output logic [HPG_W-1:0]       headphone_gain_select_wr,
   output logic                   headphone_gain_select_we
);
   int timeouts = 0;
   // idle bus at time zero
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {headphone_gain_select_wr, headphone_gain_select_we} = '0;
   end
   ////////////////////////////////
   // one strobe cycle, address and data held until ack
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      int n;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(posedge sys_clk);
      #1;
      {reg_wr, reg_rd} = 2'h0;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (reg_ack !== 1'b1 && n < 4);
      q = reg_rdata;
      if (reg_ack !== 1'b1) timeouts++;
      #1;
      reg_wdata = ~d; // released data never looks valid
      // one idle edge, so the next call never reassigns in this time step
      @(posedge sys_clk);
      #1;
   endtask : xfer
   // headphone select only ever reaches the bank by a write
   task automatic hp(input logic [HPG_W-1:0] s);
      headphone_gain_select_wr = s;
      headphone_gain_select_we = 1'b1;
      @(posedge sys_clk);
      #1;
      headphone_gain_select_we = 1'b0;
   endtask : hp
endmodule : agv_host_model

//--- tb/agv_regs_chk.sv
// agv_regs_chk: port assertions for the gain and volume bank.
// assumes one clock domain, bound onto agv_regs.
`timescale 1ns/10ps
module agv_chk
   import agv_pkg::*;
(
   input wire logic                   sys_clk,
   input wire logic                   rst_b,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire logic [HPG_W-1:0]       headphone_gain_select_wr,
   input wire logic                   headphone_gain_select_we,
   input wire logic [MODE_W-1:0]      mux_mode,
   input wire logic [TEMP_W-1:0]      die_temp_c,
   input wire logic [DATA_W-1:0]      reg_rdata,
   input wire logic                   reg_ack,
   input wire logic [HPG_W-1:0]       headphone_gain_select,
   input wire logic signed [DB_W-1:0] hp_left_total_db,
   input wire logic signed [DB_W-1:0] spk_left_total_db,
   input wire logic signed [DB_W-1:0] spk_right_total_db,
   input wire logic                   amp_shutdown
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic signed [DB_W-1:0] hp_off;
   // headphone stage offset of the current select
   always_comb hp_off = (headphone_gain_select == 2'h0) ? 8'sh06 :
                        (headphone_gain_select == 2'h1) ? 8'sh00 :
                        (headphone_gain_select == 2'h2) ? -8'sh06 : -8'sh0E;
   ////////////////////////////////
   // settle windows, the temperature path has two sync stages
   sequence hot_s; (die_temp_c > TEMP_TRIP_C)[*5]; endsequence
   sequence cool_s; (die_temp_c <= TEMP_TRIP_C)[*5]; endsequence
   sequence settled_s;
      ($stable(headphone_gain_select) && $stable(spk_left_total_db))[*3];
   endsequence
   ack_follows_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
      else $error("no ack after strobe");
   upper_zero_a: assert property ($past(reg_rd) && reg_ack |-> reg_rdata[7:5] == 3'h0)
      else $error("upper read bits set");
   hp_load_a: assert property (headphone_gain_select_we |=>
      headphone_gain_select == $past(headphone_gain_select_wr)) else $error("select not loaded");
   hp_hold_a: assert property (!headphone_gain_select_we |=> $stable(headphone_gain_select))
      else $error("select moved without write");
   hp_total_a: assert property (settled_s |->
      hp_left_total_db == spk_left_total_db - SPK_GAIN_DB + hp_off) else $error("hp total wrong");
   pair_both_a: assert property ((mux_mode == 3'h3)[*6] |->
      spk_left_total_db == spk_right_total_db) else $error("channels differ");
   thermal_trip_a: assert property (hot_s |-> amp_shutdown) else $error("no shutdown");
   thermal_clear_a: assert property (cool_s |-> !amp_shutdown) else $error("stuck shutdown");
endmodule : agv_chk
bind agv_regs agv_chk u_agv_chk (
   .sys_clk                  (sys_clk),
   .rst_b                    (rst_b),
   .reg_wr                   (reg_wr),
   .reg_rd                   (reg_rd),
   .headphone_gain_select_wr (headphone_gain_select_wr),
   .headphone_gain_select_we (headphone_gain_select_we),
   .mux_mode                 (mux_mode),
   .die_temp_c               (die_temp_c),
   .reg_rdata                (reg_rdata),
   .reg_ack                  (reg_ack),
   .headphone_gain_select    (headphone_gain_select),
   .hp_left_total_db         (hp_left_total_db),
   .spk_left_total_db        (spk_left_total_db),
   .spk_right_total_db       (spk_right_total_db),
   .amp_shutdown             (amp_shutdown)
);

//--- tb/tb.sv
// tb: register access scenarios for the gain and volume bank.
// assumes agv_host_model drives the access port.
`timescale 1ns/10ps
module tb;
   import agv_pkg::*;
   logic                   sys_clk = 1'b0;
   logic                   rst_b = 1'b0;
   logic                   reg_wr, reg_rd, reg_ack, headphone_gain_select_we, amp_shutdown;
   logic [ADDR_W-1:0]      reg_addr;
   logic [DATA_W-1:0]      reg_wdata, reg_rdata;
   logic [HPG_W-1:0]       headphone_gain_select_wr, headphone_gain_select;
   logic [MODE_W-1:0]      mux_mode = 3'h0;
   logic [TEMP_W-1:0]      die_temp_c = 9'h019;
   logic signed [DB_W-1:0] hp_left_total_db, hp_right_total_db;
   logic signed [DB_W-1:0] spk_left_total_db, spk_right_total_db;
   logic signed [DB_W-1:0] sp_exp [0:7] = '{-8'sd38, 8'sd30, -8'sd60, 8'sd30,
                                            8'sd30, 8'sd30, -8'sd60, -8'sd38};
   logic signed [DB_W-1:0] hp_exp [0:3] = '{8'sd30, 8'sd24, 8'sd18, 8'sd10};
   int                     error_cnt = 0;
   int                     check_count = 0;
   agv_regs u_agv_regs (.*);
   agv_host_model u_agv_host_model (.*);
   // 50 MHz clock
   initial forever #10 sys_clk = ~sys_clk;
   ////////////////////////////////
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_agv_host_model.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      logic [7:0] q;
      u_agv_host_model.xfer(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rd
   task automatic close_out;
      error_cnt += u_agv_host_model.timeouts;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   ////////////////////////////////
   // reset, map, taper, modes, headphone select, thermal, second reset
   initial begin
      step(2);
      rst_b = 1'b1;
      chk(headphone_gain_select, 8'h00);
      for (int i = 4; i < 7; i++) rd(ADDR_W'(i), 8'h10);
      wr(3'h7, 8'hFF);
      rd(3'h7, 8'h00);
      wr(MONO_INPUT_VOLUME_IDX, 8'hE3);
      wr(STEREO_PAIR_ONE_VOLUME_IDX, 8'h3F);
      wr(STEREO_PAIR_TWO_VOLUME_IDX, 8'hA0);
      rd(MONO_INPUT_VOLUME_IDX, 8'h03);
      rd(STEREO_PAIR_ONE_VOLUME_IDX, 8'h1F);
      rd(STEREO_PAIR_TWO_VOLUME_IDX, 8'h00);
      for (int m = 0; m < 8; m++) begin
         mux_mode = 3'(m);
         step(7);
         chk(spk_left_total_db, sp_exp[m]);
         chk(spk_right_total_db, sp_exp[m]);
      end
      mux_mode = 3'h1;
      for (int s = 0; s < 4; s++) begin
         u_agv_host_model.hp(s[1:0]);
         step(6);
         chk(headphone_gain_select, 8'(s));
         chk(hp_left_total_db, hp_exp[s]);
         chk(hp_right_total_db, hp_exp[s]);
      end
      mux_mode = 3'h0;
      wr(MONO_INPUT_VOLUME_IDX, 8'h10);
      step(6);
      chk(spk_left_total_db, 8'h06);
      for (int t = 0; t < 3; t++) begin
         die_temp_c = (t == 1) ? 9'h097 : 9'h096;
         step(6);
         chk(amp_shutdown, t == 1);
      end
      rst_b = 1'b0;
      step(2);
      rst_b = 1'b1;
      rd(STEREO_PAIR_ONE_VOLUME_IDX, 8'h10);
      chk(headphone_gain_select, 8'h00);
      close_out();
   end
endmodule : tb
